// ---- cbi_pkg.sv ----
// shared constants and types for the cpu bus control interface
package cbi_pkg;
   localparam int DATA_W = 16;
   localparam int COND_SEL_W = 4;
   // bus state codes {bus_direction, bus_control_two, bus_control_one}
   localparam logic [2:0] NO_ACTION_STATE = 3'h0;
   localparam logic [2:0] ADDR_DATA_TO_ADDR_REG_STATE = 3'h1;
   localparam logic [2:0] IRQ_ADDRESS_TO_BUS_STATE = 3'h2;
   localparam logic [2:0] READ_DATA_TO_BUS_STATE = 3'h3;
   localparam logic [2:0] BUS_TO_ADDR_REG_STATE = 3'h4;
   localparam logic [2:0] WRITE_DATA_STATE = 3'h5;
   localparam logic [2:0] WRITE_STROBE_STATE = 3'h6;
   localparam logic [2:0] IRQ_ACKNOWLEDGE_STATE = 3'h7;
   // reset values
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] IRQ_VECTOR_RESET = 16'h0000;
   // end-of-irq and trap pulse lengths, in clk_sys cycles
   localparam int END_OF_IRQ_NS = 300;
   localparam int CLK_NS = 40;
   localparam int END_OF_IRQ_CYC = (END_OF_IRQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRAP_PULSE_CYC = END_OF_IRQ_CYC;
   // user-side operation codes for the device end
   typedef enum logic [2:0] {
      cbi_op_read,
      cbi_op_write,
      cbi_op_fetch,
      cbi_op_branch_ext,
      cbi_op_end_irq,
      cbi_op_soft_irq
   } cbi_op_e;
endpackage : cbi_pkg

// ---- cbi_if.sv ----
// carrier between the processor end and the external bus logic end
`timescale 1ns/1ns
interface cbi_if;
   logic bus_direction;
   logic bus_control_one;
   logic bus_control_two;
   logic [15:0] dev_data_out;
   logic dev_data_oe;
   logic [15:0] ext_data_out;
   logic ext_data_oe;
   logic [15:0] data_bus;
   logic bus_request_n;
   logic bus_grant_n;
   logic bus_data_ready;
   logic irq_request;
   logic masked_irq_request;
   logic end_of_irq_pulse;
   logic [3:0] ext_condition_select;
   logic ext_condition_return;
   logic pc_trap_dev_out;
   logic pc_trap_dev_oe;
   logic pc_trap_ext_out;
   logic pc_trap_ext_oe;
   logic pc_inhibit_trap;
   logic stop_start_toggle;
   logic halt;
   logic master_sync_n;
   // wire resolution: pulled up when idle
   assign data_bus = dev_data_oe ? dev_data_out : (ext_data_oe ? ext_data_out : 16'hffff);
   assign pc_inhibit_trap = pc_trap_dev_oe ? pc_trap_dev_out : (pc_trap_ext_oe ? pc_trap_ext_out : 1'h1);
   modport dev (
      output bus_direction, bus_control_one, bus_control_two, dev_data_out, dev_data_oe,
      input data_bus, bus_request_n, bus_data_ready, irq_request, masked_irq_request,
      output bus_grant_n, end_of_irq_pulse, ext_condition_select, halt,
      input ext_condition_return, stop_start_toggle, master_sync_n, pc_inhibit_trap,
      output pc_trap_dev_out, pc_trap_dev_oe
   );
   modport ext (
      input bus_direction, bus_control_one, bus_control_two, data_bus, bus_grant_n,
      input end_of_irq_pulse, ext_condition_select, halt, pc_inhibit_trap,
      output ext_data_out, ext_data_oe, bus_request_n, bus_data_ready, irq_request,
      output masked_irq_request, ext_condition_return, stop_start_toggle, master_sync_n,
      output pc_trap_ext_out, pc_trap_ext_oe
   );
endinterface : cbi_if

// ---- cbi_device.sv ----
// processor end: bus sequencer, run control, interrupts, external branch
`timescale 1ns/1ns
// What this block does
// - drive three-bit bus state code on outputs
// - no action: data bus left undriven
// - address-data state: bus undriven, memory drives
// - interrupt address state: bus is input
// - read data state: device samples bus
// - bus-to-address state: device drives address
// - one shared 16-bit bus for everything
// - one flat 65,536-word address space
// - stop/start falling edge toggles run state
// - halt output high while stopped
// - master sync low aligns internal timing
// - branch-on-external drives four-bit condition select
// - external logic returns selected condition level
// - bus request held keeps device off bus
// - grant asserted once bus is released
// - data ready low stretches the cycle
// - interrupts serviced after current instruction ends
// - end-of-irq instruction emits output pulse
// - inhibit input during fetch freezes counter
// - software irq drives pulse on trap pin
module cbi_device #(
   parameter int ADDR_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   cbi_if.dev bus,
   input wire logic op_valid,
   input wire cbi_pkg::cbi_op_e op_code,
   input wire logic [15:0] op_addr,
   input wire logic [15:0] op_wdata,
   input wire logic [3:0] op_cond_sel,
   output logic op_ready,
   output logic op_done,
   output logic [15:0] op_rdata,
   output logic op_branch_taken,
   output logic [15:0] pc,
   output logic irq_taken,
   output logic [15:0] irq_vector
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      st_sync, st_idle, st_addr, st_data, st_strobe, st_wait, st_ack, st_vec,
      st_cond, st_pulse, st_released
   } cbi_dev_state_e;

   typedef struct packed {
      cbi_dev_state_e st;
      logic [2:0] code;
      logic [15:0] dout;
      logic doe;
      logic running;
      logic sst_prev;
      logic grant_n;
      logic eoi;
      logic trap_out;
      logic trap_oe;
      logic [3:0] cond_sel;
      logic [4:0] cnt;
      logic [15:0] pc;
      logic [15:0] rdata;
      logic branch;
      logic done;
      logic irq_taken;
      logic [15:0] vector;
      cbi_pkg::cbi_op_e op;
      logic [15:0] wdata;
      logic fetch;
   } cbi_dev_s;

   cbi_dev_s s_reg;
   cbi_dev_s s_next;
   logic [ADDR_W-1:0] addr_word;

   // the full 16-bit address reaches every word of the single space
   assign addr_word = op_addr[ADDR_W-1:0];

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'h0;
      s_next.irq_taken = 1'h0;
      s_next.eoi = 1'h0;
      s_next.sst_prev = bus.stop_start_toggle;
      // only a falling edge changes the run state
      if (s_reg.sst_prev && !bus.stop_start_toggle) begin
         s_next.running = !s_reg.running;
      end
      case (s_reg.st)
         st_sync: begin
            // timing held until master sync has been seen low
            if (!bus.master_sync_n) begin
               s_next.st = st_idle;
            end
         end
         st_idle: begin
            s_next.code = cbi_pkg::NO_ACTION_STATE;
            s_next.doe = 1'h0;
            s_next.trap_oe = 1'h0;
            if (!bus.bus_request_n) begin
               // idle means no cycle in flight, so release now
               s_next.st = st_released;
               s_next.grant_n = 1'h0;
            end else if (bus.irq_request || bus.masked_irq_request) begin
               // only sampled here, between instructions
               s_next.code = cbi_pkg::IRQ_ACKNOWLEDGE_STATE;
               s_next.st = st_ack;
            end else if (op_valid && s_reg.running) begin
               s_next.op = op_code;
               s_next.wdata = op_wdata;
               s_next.fetch = (op_code == cbi_pkg::cbi_op_fetch);
               s_next.cnt = 5'h0;
               if (op_code == cbi_pkg::cbi_op_branch_ext) begin
                  s_next.cond_sel = op_cond_sel;
                  s_next.st = st_cond;
               end else if (op_code == cbi_pkg::cbi_op_end_irq) begin
                  // raised at the take so the pulse spans the full count
                  s_next.eoi = 1'h1;
                  s_next.st = st_pulse;
               end else if (op_code == cbi_pkg::cbi_op_soft_irq) begin
                  s_next.trap_oe = 1'h1;
                  s_next.trap_out = 1'h0;
                  s_next.st = st_pulse;
               end else begin
                  // device puts the address on the shared bus
                  s_next.code = cbi_pkg::BUS_TO_ADDR_REG_STATE;
                  s_next.dout = 16'(addr_word);
                  s_next.doe = 1'h1;
                  s_next.st = st_addr;
               end
            end
         end
         st_addr: begin
            if (s_reg.op == cbi_pkg::cbi_op_write) begin
               s_next.code = cbi_pkg::WRITE_DATA_STATE;
               s_next.dout = s_reg.wdata;
               s_next.doe = 1'h1;
            end else begin
               s_next.code = cbi_pkg::READ_DATA_TO_BUS_STATE;
               s_next.doe = 1'h0;
            end
            s_next.st = st_data;
         end
         st_data: begin
            // slow party holds data ready low to stretch
            if (s_reg.op == cbi_pkg::cbi_op_write) begin
               if (bus.bus_data_ready) begin
                  s_next.code = cbi_pkg::WRITE_STROBE_STATE;
                  s_next.st = st_strobe;
               end
            end else if (s_reg.cnt == 5'h0) begin
               // the responder registers its drive, so the datum lands one cycle late
               s_next.cnt = 5'h01;
            end else if (bus.bus_data_ready) begin
               s_next.rdata = bus.data_bus;
               s_next.code = cbi_pkg::NO_ACTION_STATE;
               s_next.st = st_wait;
            end
         end
         st_strobe: begin
            s_next.code = cbi_pkg::NO_ACTION_STATE;
            s_next.doe = 1'h0;
            s_next.st = st_wait;
         end
         st_wait: begin
            // one resync cycle; on a fetch the counter then moves unless inhibited
            if (s_reg.fetch && bus.pc_inhibit_trap) begin
               s_next.pc = s_reg.pc + 16'h0001;
            end
            s_next.done = 1'h1;
            s_next.st = st_idle;
         end
         st_ack: begin
            // interrupting party drives its address; device only listens
            s_next.code = cbi_pkg::IRQ_ADDRESS_TO_BUS_STATE;
            s_next.cnt = 5'h0;
            s_next.st = st_vec;
         end
         st_vec: begin
            if (s_reg.cnt == 5'h0) begin
               // same one-cycle lag as a read before the vector is on the bus
               s_next.cnt = 5'h01;
            end else if (bus.bus_data_ready) begin
               s_next.vector = bus.data_bus;
               s_next.irq_taken = 1'h1;
               s_next.code = cbi_pkg::NO_ACTION_STATE;
               s_next.st = st_idle;
            end
         end
         st_cond: begin
            // settle one cycle, then take the returned level
            s_next.cnt = s_reg.cnt + 5'h01;
            if (s_reg.cnt != 5'h0) begin
               s_next.branch = bus.ext_condition_return;
               s_next.done = 1'h1;
               s_next.st = st_idle;
            end
         end
         st_pulse: begin
            s_next.eoi = (s_reg.op == cbi_pkg::cbi_op_end_irq);
            s_next.cnt = s_reg.cnt + 5'h01;
            if (s_reg.cnt == 5'(cbi_pkg::END_OF_IRQ_CYC - 1)) begin
               s_next.eoi = 1'h0;
               s_next.trap_oe = 1'h0;
               s_next.done = 1'h1;
               s_next.st = st_idle;
            end
         end
         st_released: begin
            // stay off the bus while the request is held
            if (bus.bus_request_n) begin
               s_next.grant_n = 1'h1;
               s_next.st = st_idle;
            end
         end
         default: s_next.st = st_idle;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.st <= st_sync;
         s_reg.grant_n <= 1'h1;
         s_reg.running <= 1'h1;
         s_reg.sst_prev <= 1'h1;
         s_reg.trap_out <= 1'h1;
         s_reg.pc <= cbi_pkg::ADDR_RESET;
         s_reg.vector <= cbi_pkg::IRQ_VECTOR_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign bus.bus_direction = s_reg.code[2];
   assign bus.bus_control_two = s_reg.code[1];
   assign bus.bus_control_one = s_reg.code[0];
   assign bus.dev_data_out = s_reg.dout;
   assign bus.dev_data_oe = s_reg.doe;
   assign bus.bus_grant_n = s_reg.grant_n;
   assign bus.halt = !s_reg.running;
   assign bus.end_of_irq_pulse = s_reg.eoi;
   assign bus.ext_condition_select = s_reg.cond_sel;
   assign bus.pc_trap_dev_out = s_reg.trap_out;
   assign bus.pc_trap_dev_oe = s_reg.trap_oe;
   assign op_ready = (s_reg.st == st_idle) && s_reg.running && bus.bus_request_n;
   assign op_done = s_reg.done;
   assign op_rdata = s_reg.rdata;
   assign op_branch_taken = s_reg.branch;
   assign pc = s_reg.pc;
   assign irq_taken = s_reg.irq_taken;
   assign irq_vector = s_reg.vector;
endmodule : cbi_device

// ---- cbi_external.sv ----
// external bus logic end: address latch, responder, condition select, requests
`timescale 1ns/1ns
module cbi_external (
   input wire logic clk_sys,
   input wire logic rst,
   cbi_if.ext bus,
   input wire logic [15:0] read_data,
   input wire logic [15:0] irq_address,
   input wire logic [15:0] conditions,
   input wire logic slow_ready,
   input wire logic dma_request,
   input wire logic irq_in,
   input wire logic masked_irq_in,
   input wire logic inhibit_pc,
   input wire logic stop_start_in,
   input wire logic sync_n_in,
   output logic [15:0] latched_addr,
   output logic [15:0] written_data,
   output logic write_pulse,
   output logic dma_granted,
   output logic trap_seen
);
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic [15:0] dout;
      logic doe;
      logic rdy;
      logic bus_request_n_n;
      logic irq;
      logic mirq;
      logic cond;
      logic inh;
      logic sst;
      logic sync_n;
      logic granted;
      logic trap;
   } cbi_ext_s;

   cbi_ext_s s_reg;
   cbi_ext_s s_next;
   logic [2:0] code;

   assign code = {bus.bus_direction, bus.bus_control_two, bus.bus_control_one};

   always_comb begin
      s_next = s_reg;
      s_next.wr = 1'h0;
      s_next.doe = 1'h0;
      s_next.rdy = slow_ready;
      s_next.bus_request_n_n = !dma_request;
      s_next.irq = irq_in;
      s_next.mirq = masked_irq_in;
      s_next.sst = stop_start_in;
      s_next.sync_n = sync_n_in;
      s_next.inh = inhibit_pc;
      s_next.granted = !bus.bus_grant_n;
      s_next.trap = !bus.pc_inhibit_trap && !s_reg.inh;
      // return the level picked by the select lines
      s_next.cond = conditions[bus.ext_condition_select];
      // decode the state code
      if (code == cbi_pkg::BUS_TO_ADDR_REG_STATE) begin
         s_next.addr = bus.data_bus;
      end else if (code == cbi_pkg::READ_DATA_TO_BUS_STATE) begin
         s_next.dout = read_data;
         s_next.doe = 1'h1;
      end else if (code == cbi_pkg::IRQ_ADDRESS_TO_BUS_STATE) begin
         s_next.dout = irq_address;
         s_next.doe = 1'h1;
      end else if (code == cbi_pkg::ADDR_DATA_TO_ADDR_REG_STATE) begin
         s_next.dout = s_reg.addr;
         s_next.doe = 1'h1;
      end else if (code == cbi_pkg::WRITE_DATA_STATE) begin
         s_next.wdata = bus.data_bus;
      end else if (code == cbi_pkg::WRITE_STROBE_STATE) begin
         s_next.wr = 1'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.bus_request_n_n <= 1'h1;
         s_reg.rdy <= 1'h1;
         s_reg.sst <= 1'h1;
         s_reg.sync_n <= 1'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   // drive the bus only while the decoded state asks for it
   assign bus.ext_data_out = s_reg.dout;
   assign bus.ext_data_oe = s_reg.doe && (code != cbi_pkg::NO_ACTION_STATE);
   assign bus.bus_data_ready = s_reg.rdy;
   assign bus.bus_request_n = s_reg.bus_request_n_n;
   assign bus.irq_request = s_reg.irq;
   assign bus.masked_irq_request = s_reg.mirq;
   assign bus.ext_condition_return = s_reg.cond;
   assign bus.stop_start_toggle = s_reg.sst;
   assign bus.master_sync_n = s_reg.sync_n;
   // inhibit is driven low only; trap pulses from the device read as low too
   assign bus.pc_trap_ext_out = 1'h0;
   assign bus.pc_trap_ext_oe = s_reg.inh;
   assign latched_addr = s_reg.addr;
   assign written_data = s_reg.wdata;
   assign write_pulse = s_reg.wr;
   assign dma_granted = s_reg.granted;
   assign trap_seen = s_reg.trap;
endmodule : cbi_external

// ---- cbi_properties.sv ----
// concurrent checks on the carrier between the two ends
`timescale 1ns/1ns
module cbi_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic bus_direction,
   input wire logic bus_control_one,
   input wire logic bus_control_two,
   input wire logic dev_data_oe,
   input wire logic bus_request_n,
   input wire logic bus_grant_n,
   input wire logic bus_data_ready,
   input wire logic end_of_irq_pulse,
   input wire logic pc_trap_dev_oe,
   input wire logic pc_trap_dev_out,
   input wire logic stop_start_toggle,
   input wire logic halt
);
   logic [2:0] bus_state;
   assign bus_state = {bus_direction, bus_control_two, bus_control_one};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // --------
   // bus state versus data drive
   // --------
   chk_idle_float: assert property (bus_state == cbi_pkg::NO_ACTION_STATE |-> !dev_data_oe)
      else $error("data bus driven in no-action state");
   chk_addr_data_to_addr_reg_state_float: assert property (bus_state == cbi_pkg::ADDR_DATA_TO_ADDR_REG_STATE |-> !dev_data_oe)
      else $error("data bus driven in address-data state");
   chk_input_states: assert property (bus_state inside {3'h2, 3'h3} |-> !dev_data_oe)
      else $error("data bus driven in an input state");
   chk_addr_drive: assert property (bus_state == cbi_pkg::BUS_TO_ADDR_REG_STATE |-> dev_data_oe)
      else $error("address not driven in bus-to-address state");
   chk_wait_holds: assert property (bus_state == 3'h3 && !bus_data_ready |=> bus_state == 3'h3)
      else $error("read cycle not stretched while not ready");
   // --------
   // bus release, pulses, run control
   // --------
   chk_grant_float: assert property (!bus_grant_n |-> bus_state == 3'h0 && !dev_data_oe)
      else $error("device on the bus while granted");
   chk_grant_cause: assert property (!bus_grant_n |-> !$past(bus_request_n) || !$past(bus_request_n, 2))
      else $error("grant without a request");
   chk_grant_soon: assert property ($fell(bus_request_n) |-> ##[1:12] !bus_grant_n)
      else $error("bus request not granted in time");
   chk_eoi_width: assert property ($rose(end_of_irq_pulse) |-> end_of_irq_pulse [*8] ##1 !end_of_irq_pulse)
      else $error("end-of-irq pulse has wrong length");
   chk_trap_width: assert property ($rose(pc_trap_dev_oe) |-> (pc_trap_dev_oe && !pc_trap_dev_out) [*8])
      else $error("trap pulse has wrong length or level");
   chk_stop_edge: assert property ($fell(stop_start_toggle) && !halt |-> ##[1:3] halt)
      else $error("falling edge did not stop the processor");
   chk_start_edge: assert property ($fell(stop_start_toggle) && halt |-> ##[1:3] !halt)
      else $error("falling edge did not restart the processor");
endmodule : cbi_properties

// ---- cpu_bus_control_interface_tb_top.sv ----
// self-checking bench: device end and external end joined through the carrier
`timescale 1ns/1ns
module cpu_bus_control_interface_tb_top;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic op_valid = 1'h0;
   cbi_pkg::cbi_op_e op_code = cbi_pkg::cbi_op_read;
   logic [15:0] op_addr = 16'h0000;
   logic [15:0] op_wdata = 16'h0000;
   logic [3:0] op_cond_sel = 4'h0;
   logic op_ready, op_done, op_branch_taken, irq_taken, write_pulse, dma_granted, trap_seen;
   logic [15:0] op_rdata, pc, irq_vector, latched_addr, written_data, pc0;
   logic [15:0] read_data = 16'h0000;
   logic [15:0] irq_address = 16'h0000;
   logic [15:0] conditions = 16'h8421;
   logic slow_ready = 1'h1;
   logic dma_request = 1'h0;
   logic irq_in = 1'h0;
   logic masked_irq_in = 1'h0;
   logic inhibit_pc = 1'h0;
   logic stop_start_in = 1'h1;
   logic sync_n_in = 1'h1;
   int n_fail = 0;
   int num_checks = 0;
   int eoi_cnt = 0;
   int trap_cnt = 0;
   int lat;
   int k;
   cbi_if bus_if ();
   cbi_device cbi_device_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus_if.dev), .op_valid(op_valid),
      .op_code(op_code), .op_addr(op_addr), .op_wdata(op_wdata), .op_cond_sel(op_cond_sel),
      .op_ready(op_ready), .op_done(op_done), .op_rdata(op_rdata), .op_branch_taken(op_branch_taken),
      .pc(pc), .irq_taken(irq_taken), .irq_vector(irq_vector));
   cbi_external cbi_external_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus_if.ext), .read_data(read_data),
      .irq_address(irq_address), .conditions(conditions), .slow_ready(slow_ready), .dma_request(dma_request),
      .irq_in(irq_in), .masked_irq_in(masked_irq_in), .inhibit_pc(inhibit_pc), .stop_start_in(stop_start_in),
      .sync_n_in(sync_n_in), .latched_addr(latched_addr), .written_data(written_data),
      .write_pulse(write_pulse), .dma_granted(dma_granted), .trap_seen(trap_seen));
   cbi_properties cbi_properties_inst (.clk_sys(clk_sys), .rst(rst), .bus_direction(bus_if.bus_direction),
      .bus_control_one(bus_if.bus_control_one), .bus_control_two(bus_if.bus_control_two),
      .dev_data_oe(bus_if.dev_data_oe), .bus_request_n(bus_if.bus_request_n),
      .bus_grant_n(bus_if.bus_grant_n), .bus_data_ready(bus_if.bus_data_ready),
      .end_of_irq_pulse(bus_if.end_of_irq_pulse), .pc_trap_dev_oe(bus_if.pc_trap_dev_oe),
      .pc_trap_dev_out(bus_if.pc_trap_dev_out), .stop_start_toggle(bus_if.stop_start_toggle),
      .halt(bus_if.halt));
   always #20 clk_sys = ~clk_sys;
   // pulse widths counted on the falling edge, clear of the launching edge
   always @(negedge clk_sys) begin
      if (bus_if.end_of_irq_pulse === 1'h1) eoi_cnt++;
      if (bus_if.pc_inhibit_trap === 1'h0) trap_cnt++;
   end
   // --------
   // shared tasks
   // --------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic summarize();
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   // request held until the edge that samples op_ready high; lat counts cycles to op_done
   task automatic do_op(input cbi_pkg::cbi_op_e c, input logic [15:0] a, input logic [15:0] d,
      input logic [3:0] s);
      op_code = c;
      op_addr = a;
      op_wdata = d;
      op_cond_sel = s;
      op_valid = 1'h1;
      for (k = 0; k < 200 && op_ready !== 1'h1; k++) tick(1);
      tick(1);
      op_valid = 1'h0;
      for (lat = 0; lat < 200 && op_done !== 1'h1; lat++) begin
         if (irq_taken === 1'h1) check(16'h1, 16'h0);
         tick(1);
      end
      if (lat == 200) check(16'h0, 16'h1);
   endtask : do_op
   // --------
   // test sequence
   // --------
   initial begin
      tick(4);
      rst = 1'h0;
      sync_n_in = 1'h0;
      tick(3);
      sync_n_in = 1'h1;
      tick(3);
      check(16'({bus_if.bus_direction, bus_if.bus_control_two, bus_if.bus_control_one}), 16'h0);
      check(16'(bus_if.bus_grant_n), 16'h1);
      check(16'(bus_if.halt), 16'h0);
      do_op(cbi_pkg::cbi_op_write, 16'hfffe, 16'ha5c3, 4'h0);
      check(16'(lat), 16'h4);
      check(latched_addr, 16'hfffe);
      check(written_data, 16'ha5c3);
      read_data = 16'h1234;
      do_op(cbi_pkg::cbi_op_read, 16'h0001, 16'h0, 4'h0);
      check(op_rdata, 16'h1234);
      check(latched_addr, 16'h0001);
      check(16'(lat), 16'h4);
      slow_ready = 1'h0;
      read_data = 16'hbeef;
      fork
         do_op(cbi_pkg::cbi_op_read, 16'h8000, 16'h0, 4'h0);
         begin
            tick(8);
            slow_ready = 1'h1;
         end
      join
      check(op_rdata, 16'hbeef);
      check(16'(lat > 6), 16'h1);
      for (int i = 0; i < 16; i++) begin
         do_op(cbi_pkg::cbi_op_branch_ext, 16'h0, 16'h0, 4'(i));
         check(16'(bus_if.ext_condition_select), 16'(i));
         check(16'(op_branch_taken), 16'(conditions[i]));
      end
      pc0 = pc;
      do_op(cbi_pkg::cbi_op_fetch, 16'h0, 16'h0, 4'h0);
      check(pc, pc0 + 16'h1);
      inhibit_pc = 1'h1;
      tick(2);
      pc0 = pc;
      do_op(cbi_pkg::cbi_op_fetch, 16'h0, 16'h0, 4'h0);
      check(pc, pc0);
      inhibit_pc = 1'h0;
      tick(2);
      eoi_cnt = 0;
      do_op(cbi_pkg::cbi_op_end_irq, 16'h0, 16'h0, 4'h0);
      tick(2);
      check(16'(eoi_cnt), 16'h8);
      trap_cnt = 0;
      do_op(cbi_pkg::cbi_op_soft_irq, 16'h0, 16'h0, 4'h0);
      check(16'(trap_seen), 16'h1);
      tick(2);
      check(16'(trap_cnt), 16'h8);
      // plain and masked request, each raised while a write is under way
      for (int j = 0; j < 2; j++) begin
         irq_address = 16'h0abc + 16'(j);
         fork
            do_op(cbi_pkg::cbi_op_write, 16'h0100, 16'h5a5a, 4'h0);
            begin
               tick(2);
               if (j == 0) irq_in = 1'h1;
               else masked_irq_in = 1'h1;
            end
         join
         for (k = 0; k < 50 && irq_taken !== 1'h1; k++) tick(1);
         irq_in = 1'h0;
         masked_irq_in = 1'h0;
         tick(3);
         check(irq_vector, 16'h0abc + 16'(j));
         tick(8);
      end
      // bus request arriving in mid-cycle: the read must finish first
      read_data = 16'h0f0f;
      fork
         do_op(cbi_pkg::cbi_op_read, 16'h0002, 16'h0, 4'h0);
         begin
            tick(2);
            dma_request = 1'h1;
         end
      join
      check(op_rdata, 16'h0f0f);
      for (k = 0; k < 20 && bus_if.bus_grant_n !== 1'h0; k++) tick(1);
      tick(2);
      check(16'(bus_if.dev_data_oe), 16'h0);
      check(16'(dma_granted), 16'h1);
      op_code = cbi_pkg::cbi_op_write;
      op_valid = 1'h1;
      tick(4);
      check(16'(op_ready), 16'h0);
      op_valid = 1'h0;
      dma_request = 1'h0;
      tick(4);
      check(16'(bus_if.bus_grant_n), 16'h1);
      stop_start_in = 1'h0;
      tick(4);
      check(16'(bus_if.halt), 16'h1);
      check(16'(op_ready), 16'h0);
      stop_start_in = 1'h1;
      tick(4);
      check(16'(bus_if.halt), 16'h1);
      stop_start_in = 1'h0;
      tick(4);
      check(16'(bus_if.halt), 16'h0);
      stop_start_in = 1'h1;
      tick(2);
      summarize();
   end
   // a hang is cut off well beyond the few hundred cycles the tests need
   initial begin
      #(40 * 4000);
      n_fail++;
      summarize();
   end
endmodule : cpu_bus_control_interface_tb_top
